// file: ifa_irq_fiq_aggregator.sv
// Interrupt aggregator top: enables, status registers, IRQ/FIQ outputs
// Notes for users of this block:
// - Requests are levels; the source must drop its line, since
//   nothing here latches or clears an event.
// - A request pin reaches irq_o or fiq_o three edges after it
//   moves: two synchroniser stages and the output register.
//   A pulse shorter than one clock may be missed entirely.
// - There is no vector and no priority inside a group; the
//   handler reads the masked status and picks a source itself.
// - Enable-clear is write only and reads back as zero; the
//   current enables are read at the enable-set offset.
// - Every access takes one wait cycle; read data are taken in
//   the wait cycle, so the raw view is the synchronised one.
// - Byte lanes mask enable writes; upper four bits of the top
//   lane are reserved and never stored.
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ifa_irq_fiq_aggregator
	import ifa_pkg::*;
(
	// Clock and reset
	input  wire logic              core_clk_i,
	input  wire logic              sys_rst_i,
	// Request lines from peripherals and pins
	input  wire logic [27:0]       req_i,
	// Avalon-MM slave
	input  wire logic [IFA_AW-1:0] avs_address_i,
	input  wire logic              avs_read_i,
	input  wire logic              avs_write_i,
	input  wire logic [3:0]        avs_byteenable_i,
	input  wire logic [31:0]       avs_writedata_i,
	output logic [31:0]            avs_readdata_o,
	output logic                   avs_waitrequest_o,
	// Lines to the processor core
	output logic                   irq_o,
	output logic                   fiq_o
);
	// Two-stage synchroniser on requests that may come from pins
	logic [27:0] req_s1_r;      // First stage, read only by second
	logic [27:0] req_s2_r;      // Synchronised raw requests
	logic [27:0] en_r;          // Source enables
	logic [27:0] en_nxt;        // Next enables
	logic        irq_r;         // Registered IRQ
	logic        irq_nxt;       // Next IRQ
	logic        fiq_r;         // Registered FIQ
	logic        fiq_nxt;       // Next FIQ
	logic [31:0] rd_r;          // Read data register
	logic [31:0] rd_nxt;        // Next read data
	ifa_bus_st_t st_r;          // Bus phase
	ifa_bus_st_t st_nxt;        // Next bus phase
	logic [31:0] wmask;         // Byte lanes expanded to bits
	logic        wr_ens;        // Write to enable-set accepted
	logic        wr_enc;        // Write to enable-clear accepted

	// Shared connection to the mask combiner
	ifa_src_if src ();
	assign src.raw    = req_s2_r;
	assign src.enable = en_r;

	ifa_combiner u_comb (
		.s (src)
	);

	// Expand byte enables to a bit mask
	function automatic logic [31:0] lanes(input logic [3:0] be);
		lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// Pad a 28-bit vector to the bus, reserved bits zero
	function automatic logic [31:0] pad(input logic [27:0] v);
		pad = {IFA_RSV_VAL, v};
	endfunction

	// Writes take effect at the acknowledge edge only
	assign wmask  = lanes(avs_byteenable_i);
	assign wr_ens = (st_r == IFA_ACK) && avs_write_i
	                && (avs_address_i == IFA_OFS_ENS);
	assign wr_enc = (st_r == IFA_ACK) && avs_write_i
	                && (avs_address_i == IFA_OFS_ENC);

	// Bus phase: one wait cycle, then acknowledge
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			IFA_IDLE: begin
				if (avs_read_i || avs_write_i) begin
					st_nxt = IFA_ACK;
				end
			end
			IFA_ACK: begin
				st_nxt = IFA_IDLE;
			end
		endcase
	end

	// Waitrequest low only in the acknowledge cycle
	assign avs_waitrequest_o = !(st_r == IFA_ACK);

	// Enable update; bits 31..28 of write data are dropped
	always_comb begin
		en_nxt = en_r;
		if (wr_ens) begin
			// Ones set, zeros leave alone
			en_nxt = en_nxt | (avs_writedata_i[27:0] & wmask[27:0]);
		end
		if (wr_enc) begin
			// Ones clear, zeros leave alone
			en_nxt = en_nxt & ~(avs_writedata_i[27:0] & wmask[27:0]);
		end
	end

	// Read data captured in the wait cycle, shown at acknowledge
	always_comb begin
		rd_nxt = rd_r;
		if (st_r == IFA_IDLE && avs_read_i) begin
			unique case (avs_address_i)
				IFA_OFS_MSK: rd_nxt = pad(src.masked);
				IFA_OFS_RAW: rd_nxt = pad(req_s2_r);
				IFA_OFS_ENS: rd_nxt = pad(en_r);
				default:     rd_nxt = IFA_UNMAPPED;      // Enable-clear, holes
			endcase
		end
	end
	assign avs_readdata_o = rd_r;

	// Group ORs; no ordering between sources inside a group
	always_comb begin
		irq_nxt = |src.masked[27:IFA_IRQ_LOW];
		fiq_nxt = |src.masked[IFA_FIQ_TOP:0];
	end
	assign irq_o = irq_r;
	assign fiq_o = fiq_r;

	// All state registered; enables cleared at reset
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			req_s1_r <= '0;
			req_s2_r <= '0;
			en_r     <= IFA_EN_RST;
			irq_r    <= 1'b0;
			fiq_r    <= 1'b0;
			rd_r     <= '0;
			st_r     <= IFA_IDLE;
		end else begin
			req_s1_r <= req_i;
			req_s2_r <= req_s1_r;
			en_r     <= en_nxt;
			irq_r    <= irq_nxt;
			fiq_r    <= fiq_nxt;
			rd_r     <= rd_nxt;
			st_r     <= st_nxt;
		end
	end

	// Checks on the outputs and register effects
	irq_follows_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		irq_o == $past(|(req_s2_r[27:4] & en_r[27:4])))
		else $error("irq does not follow enabled high sources");
	fiq_follows_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		fiq_o == $past(|(req_s2_r[3:0] & en_r[3:0])))
		else $error("fiq does not follow enabled low sources");
	masked_off_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(en_r == '0) |=> !irq_o && !fiq_o)
		else $error("output raised with no source enabled");
	set_ones_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		wr_ens && !wr_enc |=> ((en_r & $past(avs_writedata_i[27:0]
		& wmask[27:0])) == $past(avs_writedata_i[27:0] & wmask[27:0])))
		else $error("enable set write lost a bit");
	clear_ones_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		wr_enc |=> ((en_r & $past(avs_writedata_i[27:0] & wmask[27:0]))
		== '0))
		else $error("enable clear write kept a bit");
	hold_en_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		!wr_ens && !wr_enc |=> $stable(en_r))
		else $error("enables changed without a write");
	reset_en_a: assert property (@(posedge core_clk_i)
		sys_rst_i |=> en_r == '0)
		else $error("enables not cleared by reset");
	rsv_zero_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		avs_readdata_o[31:28] == 4'h0)
		else $error("reserved bits read nonzero");
	ens_read_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		st_r == IFA_IDLE && avs_read_i && avs_address_i == IFA_OFS_ENS
		|=> avs_readdata_o[27:0] == $past(en_r))
		else $error("enable read does not show enables");
	msk_read_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		st_r == IFA_IDLE && avs_read_i && avs_address_i == IFA_OFS_MSK
		|=> avs_readdata_o[27:0] == $past(req_s2_r & en_r))
		else $error("masked read is not raw and enable");
	ack_one_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("acknowledge held longer than one cycle");

	// Fast sources alone never reach the normal line
	fiq_not_irq_a: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(src.masked[27:4] == '0) |=> !irq_o)
		else $error("fast source raised the normal line");

	// Normal sources alone never reach the fast line
	irq_not_fiq_a: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(src.masked[3:0] == '0) |=> !fiq_o)
		else $error("normal source raised the fast line");

	// A held, enabled request keeps the normal line up
	irq_level_a: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(|src.masked[27:4]) |=> irq_o)
		else $error("normal line dropped while request held");

	// A held, enabled request keeps the fast line up
	fiq_level_a: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(|src.masked[3:0]) |=> fiq_o)
		else $error("fast line dropped while request held");

	// Raw view ignores enables
	raw_read_a: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		st_r == IFA_IDLE && avs_read_i && avs_address_i == IFA_OFS_RAW
		|=> avs_readdata_o[27:0] == $past(req_s2_r))
		else $error("raw read does not show requests");

	// Enable-clear is write only and reads as the unmapped value
	enc_read_a: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		st_r == IFA_IDLE && avs_read_i && avs_address_i == IFA_OFS_ENC
		|=> avs_readdata_o == IFA_UNMAPPED)
		else $error("enable clear read is not zero");

	// A write of zeros or of reserved bits only leaves enables alone
	rsv_write_a: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(wr_ens || wr_enc) && (avs_writedata_i[27:0] & wmask[27:0]) == '0
		|=> $stable(en_r))
		else $error("write of no source bits changed enables");

	// A set write raises only the bits written
	set_only_a: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		wr_ens |=> (en_r & ~$past(en_r))
		== ($past(avs_writedata_i[27:0] & wmask[27:0]) & ~$past(en_r)))
		else $error("enable set write raised an unwritten bit");

	// A clear write drops only the bits written
	clr_only_a: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		wr_enc |=> ($past(en_r) & ~en_r)
		== ($past(avs_writedata_i[27:0] & wmask[27:0]) & $past(en_r)))
		else $error("enable clear write dropped an unwritten bit");

	// Reset leaves both lines low
	rst_lines_a: assert property (
		@(posedge core_clk_i)
		sys_rst_i |=> !irq_o && !fiq_o)
		else $error("line high after reset");

	// Every request is answered in the next cycle
	ack_next_a: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		st_r == IFA_IDLE && (avs_read_i || avs_write_i)
		|=> !avs_waitrequest_o)
		else $error("request not answered after one wait");

	// Read data stand until the next read is taken
	rd_hold_a: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		!(st_r == IFA_IDLE && avs_read_i) |=> $stable(avs_readdata_o))
		else $error("read data changed without a read");

	// Main scenarios reached
	irq_seen_c: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
		irq_o && !fiq_o);
	fiq_seen_c: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
		fiq_o && !irq_o);
	both_seen_c: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
		irq_o && fiq_o);
	set_clr_c: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
		wr_ens ##[1:20] wr_enc);
	masked_req_c: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
		|req_s2_r && !irq_o && !fiq_o);
endmodule
`default_nettype wire

// file: ifa_pkg.sv
// Package for the interrupt aggregator: map, widths and field layout
package ifa_pkg;
	localparam int          IFA_NSRC      = 28;      // Number of request sources
	localparam int          IFA_DW        = 32;      // Bus data width
	localparam int          IFA_AW        = 5;       // Byte address width
	localparam int          IFA_FIQ_TOP   = 3;       // Highest fast source
	localparam int          IFA_IRQ_LOW   = 4;       // Lowest normal source
	localparam logic [4:0]  IFA_OFS_MSK   = 5'h00;   // Masked status
	localparam logic [4:0]  IFA_OFS_RAW   = 5'h04;   // Raw request status
	localparam logic [4:0]  IFA_OFS_ENS   = 5'h08;   // Enable set
	localparam logic [4:0]  IFA_OFS_ENC   = 5'h0c;   // Enable clear
	localparam logic [27:0] IFA_EN_RST    = 28'h0;   // Enables after reset
	localparam logic [3:0]  IFA_RSV_VAL   = 4'h0;    // Reserved bits read
	localparam logic [31:0] IFA_UNMAPPED  = 32'h0;   // Unmapped read value
	// Bus slave phases
	typedef enum logic [0:0] {IFA_IDLE, IFA_ACK} ifa_bus_st_t;
endpackage

// file: ifa_src_if.sv
// Interface carrying request and enable vectors to the combiner
`timescale 1ns/1ps
`default_nettype none
interface ifa_src_if;
	logic [27:0] raw;     // Synchronised raw requests
	logic [27:0] enable;  // Current enable bits
	logic [27:0] masked;  // Raw AND enable
	modport ctrl (output raw, output enable, input masked);
	modport comb (input raw, input enable, output masked);
endinterface
`default_nettype wire

// file: ifa_combiner.sv
// Masking of requests by enables, combinational
`timescale 1ns/1ps
`default_nettype none
module ifa_combiner
	import ifa_pkg::*;
(
	// Vectors from the controller
	ifa_src_if.comb s
);
	// Each source gated alone; no ordering between sources
	genvar g;
	generate
		for (g = 0; g < IFA_NSRC; g++) begin : gate_g
			assign s.masked[g] = s.raw[g] & s.enable[g];
		end
	endgenerate
endmodule
`default_nettype wire

// file: ifa_core_model.sv
// Core model: which vector the core would enter for the IRQ and FIQ lines
`timescale 1ns/1ps
`default_nettype none
module ifa_core_model (
	// Clock
	input  wire logic        core_clk_i,
	// Lines from the aggregator
	input  wire logic        irq_i,
	input  wire logic        fiq_i,
	// Vector the core would take next, zero when idle
	output logic [31:0]      vec_o
);
	// Fast line wins when both are up, so its handler runs first
	always_ff @(posedge core_clk_i) begin
		if (fiq_i)
			vec_o <= 32'h0000001c;
		else if (irq_i)
			vec_o <= 32'h00000018;
		else
			vec_o <= 32'h0;
	end
endmodule
`default_nettype wire

// file: irq_fiq_interrupt_aggregator_test.sv
// Testbench for the interrupt aggregator with a core model on its outputs
`timescale 1ns/1ps
`default_nettype none
module irq_fiq_interrupt_aggregator_test;
	import ifa_pkg::*;
	logic        clk = 0;         // Core clock, 25 MHz
	logic        rst = 1;         // Synchronous reset
	logic [27:0] req = 0;         // Request levels
	logic [4:0]  adr = 0;         // Bus address
	logic        rd = 0;          // Bus read
	logic        wr = 0;          // Bus write
	logic [31:0] wd = 0;          // Bus write data
	logic [31:0] rdat;            // Bus read data
	logic        wait_r;          // Bus waitrequest
	logic        irq, fiq;        // Lines to the core
	logic [31:0] vec;             // Vector chosen by the core model
	logic [31:0] q, r, s, c, x;   // Scratch and random state
	logic [27:0] en, m;           // Expected enables and masked view
	logic [3:0]  be = 4'hf;       // Bus byte enables
	logic [27:0] bm;              // Expected write bit mask
	int          n_fail = 0;      // Mismatch count
	int          checks_done = 0; // Comparison count
	int          cyc = 0;         // Timeout counter
	always #20 clk = ~clk;
	ifa_irq_fiq_aggregator dut (.core_clk_i(clk), .sys_rst_i(rst),
		.req_i(req), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_byteenable_i(be), .avs_writedata_i(wd),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wait_r),
		.irq_o(irq), .fiq_o(fiq));
	ifa_core_model core (.core_clk_i(clk), .irq_i(irq), .fiq_i(fiq),
		.vec_o(vec));
	// Xorshift step, so every run draws the same values
	function automatic logic [31:0] nxt(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	// Byte lanes of a write as a 28-bit mask; upper lane is half reserved
	function automatic logic [27:0] lane(input logic [3:0] b);
		return {{4{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
	endfunction
	// Compare and count
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// One bus cycle; holds the request until waitrequest is seen low
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] o);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		while (wait_r !== 1'b0) @(posedge clk);
		o = rdat;
		wr <= 0;
		rd <= 0;
		@(posedge clk);
	endtask
	// Verdict and end of run
	task automatic stop_test();
		$display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			n_fail++;
			stop_test();
		end
	end
	// Main sequence: corner cases first, then random traffic
	initial begin
		x = 32'h701d;
		en = 0;
		repeat (8) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		bus(0, IFA_OFS_ENS, 0, q);
		chk(q, 0);
		chk({30'h0, irq, fiq}, 0);
		for (int i = 0; i < 40; i++) begin
			x = nxt(x); r = x;
			x = nxt(x); s = x;
			x = nxt(x); c = x & nxt(x);
			// Reserved-only set, one fast source, normal sources only
			case (i)
				0: begin r = '1; s = 32'hf0000000; c = 0; end
				1: begin r = '1; s = 32'h8; c = 0; end
				2: begin r = 32'h10; s = '1; c = 32'h8; end
				default: ;
			endcase
			req <= r[27:0];
			// One pass with only the lowest byte lane written
			be <= (i == 3) ? 4'h1 : 4'hf;
			bm = lane((i == 3) ? 4'h1 : 4'hf);
			bus(1, IFA_OFS_ENS, s, q);
			bus(1, IFA_OFS_ENC, c, q);
			en = (en | (s[27:0] & bm)) & ~(c[27:0] & bm);
			m = r[27:0] & en;
			repeat (5) @(posedge clk);
			bus(0, IFA_OFS_MSK, 0, q);
			chk(q, {4'h0, m});
			bus(0, IFA_OFS_RAW, 0, q);
			chk(q, {4'h0, r[27:0]});
			bus(0, IFA_OFS_ENS, 0, q);
			chk(q, {4'h0, en});
			chk({30'h0, irq, fiq}, {30'h0, |m[27:4], |m[3:0]});
			chk(vec, |m[3:0] ? 32'h1c : |m[27:4] ? 32'h18 : 0);
		end
		bus(0, 5'h10, 0, q);
		chk(q, IFA_UNMAPPED);
		stop_test();
	end
endmodule
`default_nettype wire
